// ==== src/bridge_power_defines.svh ====
`ifndef BRIDGE_POWER_DEFINES_SVH
`define BRIDGE_POWER_DEFINES_SVH

// System clock rate in MHz.
`define SYS_CLK_MHZ 200
// Length of the self reset after a D3hot to D0 return, in ns.
`define WAKE_RESET_NS 100
// Host clock must run this long before the host bus reset is released, in us.
`define HOST_CLK_LEAD_US 100

// Bit positions of the power-management event sources.
`define EVT_DETECT 0
`define EVT_READY 1
`define EVT_BATT 2
`define EVT_RING 3

// Reset value of the event context, and the codes of the requested state.
`define EVENTS_RESET 4'h0
`define REQ_D0 2'h0
`define REQ_D1 2'h1
`define REQ_D2 2'h2
`define REQ_D3 2'h3

`endif

// ==== src/bridge_power_pkg.sv ====
package bridge_power_pkg;

    // Device power states, one-hot.
    typedef enum logic [4:0] {
        PS_D0     = 5'h01,
        PS_D1     = 5'h02,
        PS_D2     = 5'h04,
        PS_D3HOT  = 5'h08,
        PS_D3COLD = 5'h10
    } pwr_state_e;

    // Registered state of the sequencer, all but the wake pin flop.
    typedef struct packed {
        pwr_state_e state;
        logic [3:0] events;
        logic [3:0] prevIn;
        logic [7:0] rstCnt;
        logic       cardClkEnable;
        logic       cardClkStopReq;
        logic       cardBusReset_n;
        logic       card16Reset;
        logic       socketQuiet;
        logic       cardDataFloat;
        logic       cardAddrLow;
        logic       cbParLow;
        logic       cbGntHigh;
        logic       pciIfEnable;
        logic       intOut;
        logic       pmeReq;
        logic       txnAccept;
        logic       txnReject;
    } pwr_ctx_s;

endpackage : bridge_power_pkg

// ==== src/pme_pin_driver.sv ====
`timescale 1ns/1ps
`default_nettype none

module pme_pin_driver (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pmeReq,
    input  wire logic coldWake,
    output var  logic pmeOe_n
);

    // The asynchronous set lets a wake event pull the pin with no clock running.
    always_ff @(posedge sys_clk or negedge rstn or posedge coldWake) begin
        if (!rstn) begin
            pmeOe_n <= 1'b1;
        end else if (coldWake) begin
            pmeOe_n <= 1'b0;
        end else begin
            pmeOe_n <= !pmeReq;
        end
    end

endmodule : pme_pin_driver

`default_nettype wire

// ==== src/bridge_power_state_control.sv ====
`include "bridge_power_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_power_state_control
    import bridge_power_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       host_bus_reset_n,
    input  wire logic       hw_suspend_n,
    input  wire logic       stateWrite,
    input  wire logic [1:0] stateReq,
    input  wire logic       pmeEnable,
    input  wire logic [3:0] eventMask,
    input  wire logic       eventClear,
    input  wire logic       auxPowerOnly,
    input  wire logic       cardPresent,
    input  wire logic       cardIsCardbus,
    input  wire logic       cardReadyBusy,
    input  wire logic       cardBattWarn,
    input  wire logic       cardRingInd,
    input  wire logic       pciClkStopped,
    input  wire logic       pciClkSlow,
    input  wire logic       cardClkRunAck,
    input  wire logic       irqReq,
    input  wire logic       txnValid,
    input  wire logic       txnIsConfig,
    output logic [4:0]      powerState,
    output logic [3:0]      pmeEvents,
    output logic            cardClkEnable,
    output logic            cardClkStopReq,
    output logic            cardBusReset_n,
    output logic            card16Reset,
    output logic            socketQuiet,
    output logic            cardDataFloat,
    output logic            cardAddrLow,
    output logic            cbParLow,
    output logic            cbGntHigh,
    output logic            pciIfEnable,
    output logic            intOut,
    output logic            txnAccept,
    output logic            txnReject,
    output logic            pmeOe_n
);

    // Self reset length rounds up to whole cycles.
    localparam int WAKE_CYCLES_INT = (`WAKE_RESET_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] WAKE_CYCLES = 8'(WAKE_CYCLES_INT);

    pwr_ctx_s cur;
    pwr_ctx_s next_cur;
    logic     coldWake;
    logic     hostReset;
    logic     inD3;

    // True for either flavour of D3.
    function automatic logic is_d3(input pwr_state_e s);
        is_d3 = (s == PS_D3HOT) || (s == PS_D3COLD);
    endfunction : is_d3

    assign inD3 = is_d3(cur.state);

    // Host reset acts only when neither hardware suspend nor armed D3 protects the context.
    assign hostReset = !host_bus_reset_n && hw_suspend_n && !(inD3 && pmeEnable);

    // Detect and ring work from raw pins so a wake needs no clock in D3cold.
    assign coldWake = (cur.state == PS_D3COLD) && pmeEnable &&
                      ((cardPresent ^ cur.prevIn[`EVT_DETECT]) || cardRingInd);

    // Next state of the whole sequencer.
    always_comb begin
        logic [3:0] inVec;
        logic [3:0] edges;
        logic       wantStop;
        inVec = 4'h0;
        edges = 4'h0;
        wantStop = 1'b0;
        inVec[`EVT_DETECT] = cardPresent;
        inVec[`EVT_READY]  = cardReadyBusy;
        inVec[`EVT_BATT]   = cardBattWarn;
        inVec[`EVT_RING]   = cardRingInd;
        edges = inVec ^ cur.prevIn;
        next_cur = cur;
        next_cur.prevIn = inVec;
        // A change arriving with a clear is kept.
        next_cur.events = (cur.events & ~{4{eventClear}}) | edges;
        if (cur.rstCnt != 8'h00) begin
            next_cur.rstCnt = cur.rstCnt - 8'h01;
        end
        // Requests are held off during the self reset and in D3cold.
        if (stateWrite && cur.rstCnt == 8'h00 && cur.state != PS_D3COLD) begin
            case (stateReq)
                `REQ_D0: begin
                    next_cur.state = PS_D0;
                    if (cur.state == PS_D3HOT) begin
                        next_cur.rstCnt = WAKE_CYCLES;
                    end
                end
                `REQ_D1: next_cur.state = PS_D1;
                `REQ_D2: next_cur.state = PS_D2;
                default: next_cur.state = PS_D3HOT;
            endcase
        end else if (cur.state == PS_D3HOT && auxPowerOnly) begin
            next_cur.state = PS_D3COLD;
        end
        // Card clock: D3 forces it off, D2 and host clock-run ask the card first.
        wantStop = (next_cur.state == PS_D2) || pciClkStopped || pciClkSlow;
        if (is_d3(next_cur.state)) begin
            next_cur.cardClkEnable  = 1'b0;
            next_cur.cardClkStopReq = 1'b0;
        end else if (wantStop) begin
            next_cur.cardClkStopReq = 1'b1;
            if (cardClkRunAck) begin
                next_cur.cardClkEnable = 1'b0;
            end
        end else begin
            next_cur.cardClkStopReq = 1'b0;
            next_cur.cardClkEnable  = 1'b1;
        end
        next_cur.socketQuiet   = !next_cur.cardClkEnable;
        next_cur.cbParLow      = next_cur.socketQuiet && cardPresent && cardIsCardbus;
        next_cur.cbGntHigh     = next_cur.socketQuiet && cardPresent && cardIsCardbus;
        next_cur.cardDataFloat = next_cur.socketQuiet && cardPresent && !cardIsCardbus;
        next_cur.cardAddrLow   = next_cur.socketQuiet && cardPresent && !cardIsCardbus;
        next_cur.cardBusReset_n = !(cardPresent && cardIsCardbus &&
                                    (next_cur.socketQuiet || next_cur.rstCnt != 8'h00));
        next_cur.card16Reset = cardPresent && !cardIsCardbus && next_cur.rstCnt != 8'h00;
        next_cur.pciIfEnable = hw_suspend_n && next_cur.rstCnt == 8'h00;
        next_cur.intOut = irqReq && next_cur.pciIfEnable && next_cur.state == PS_D0;
        next_cur.pmeReq = pmeEnable && next_cur.state != PS_D0 &&
                          |(next_cur.events & eventMask);
        // Suspend gates the answer at once, since the enable flop lags the pin by a cycle.
        next_cur.txnAccept = txnValid && hw_suspend_n && cur.pciIfEnable &&
                             (cur.state == PS_D0 || (txnIsConfig && cur.state != PS_D3COLD));
        next_cur.txnReject = txnValid && !next_cur.txnAccept;
        // Host reset returns the state and event context to defaults.
        if (hostReset) begin
            next_cur.state          = PS_D0;
            next_cur.events         = `EVENTS_RESET;
            next_cur.rstCnt         = 8'h00;
            next_cur.cardClkEnable  = 1'b1;
            next_cur.cardClkStopReq = 1'b0;
            next_cur.socketQuiet    = 1'b0;
            next_cur.cbParLow       = 1'b0;
            next_cur.cbGntHigh      = 1'b0;
            next_cur.cardDataFloat  = 1'b0;
            next_cur.cardAddrLow    = 1'b0;
            next_cur.cardBusReset_n = 1'b0;
            next_cur.card16Reset    = cardPresent && !cardIsCardbus;
            next_cur.pciIfEnable    = 1'b0;
            next_cur.intOut         = 1'b0;
            next_cur.pmeReq         = 1'b0;
            next_cur.txnAccept      = 1'b0;
            next_cur.txnReject      = txnValid;
        end
    end

    // Global reset puts every field at its default.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '{state: PS_D0, events: `EVENTS_RESET, prevIn: 4'h0, rstCnt: 8'h00,
                     cardClkEnable: 1'b1, cardBusReset_n: 1'b0, default: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign powerState     = cur.state;
    assign pmeEvents      = cur.events;
    assign cardClkEnable  = cur.cardClkEnable;
    assign cardClkStopReq = cur.cardClkStopReq;
    assign cardBusReset_n = cur.cardBusReset_n;
    assign card16Reset    = cur.card16Reset;
    assign socketQuiet    = cur.socketQuiet;
    assign cardDataFloat  = cur.cardDataFloat;
    assign cardAddrLow    = cur.cardAddrLow;
    assign cbParLow       = cur.cbParLow;
    assign cbGntHigh      = cur.cbGntHigh;
    assign pciIfEnable    = cur.pciIfEnable;
    assign intOut         = cur.intOut;
    assign txnAccept      = cur.txnAccept;
    assign txnReject      = cur.txnReject;

    // The wake pin has its own flop so it can set without a clock.
    pme_pin_driver pmeDrv (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .pmeReq   (cur.pmeReq),
        .coldWake (coldWake),
        .pmeOe_n  (pmeOe_n)
    );

    // Checks on the sequencer's own outputs.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence wake_req_s;
        stateWrite && stateReq == `REQ_D0 && cur.state == PS_D3HOT && cur.rstCnt == 8'h00 && !hostReset;
    endsequence

    sequence iface_off_s;
        !pciIfEnable [*8];
    endsequence

    state_onehot_a: assert property ($onehot(powerState)) else $error("power state not one-hot");
    int_gated_a: assert property (powerState != PS_D0 |-> !intOut) else $error("interrupt outside D0");
    event_sticky_a: assert property (
        $rose(cardRingInd) && !hostReset |=> pmeEvents[`EVT_RING])
        else $error("ring change not latched");
    txn_config_a: assert property (
        txnValid && !txnIsConfig && powerState != PS_D0 |=> !txnAccept && txnReject)
        else $error("memory access accepted outside D0");
    d1_clock_a: assert property (
        powerState == PS_D1 && !pciClkStopped && !pciClkSlow && !hostReset && !stateWrite |=> cardClkEnable)
        else $error("card clock stopped in D1");
    d2_handshake_a: assert property (
        powerState == PS_D2 && cardClkEnable && !cardClkRunAck && !stateWrite && !hostReset
        |=> cardClkEnable && cardClkStopReq) else $error("card clock stopped without ack");
    // Parking flops hold the card type seen one edge earlier, so the checks look back one cycle.
    d3_clock_a: assert property (
        stateWrite && stateReq == `REQ_D3 && cur.rstCnt == 8'h00 && !hostReset && cur.state != PS_D3COLD
        |=> !cardClkEnable && (!$past(cardPresent) || !$past(cardIsCardbus) || !cardBusReset_n))
        else $error("D3hot entry did not stop clock or reset card");
    wake_reset_a: assert property (wake_req_s |=> iface_off_s)
        else $error("interface enabled during self reset");
    suspend_pins_a: assert property (
        socketQuiet && $past(cardPresent) && $past(cardIsCardbus) |-> cbParLow && cbGntHigh && !cardBusReset_n)
        else $error("CardBus pins not parked");
    sixteen_pins_a: assert property (
        socketQuiet && $past(cardPresent) && !$past(cardIsCardbus) |-> cardDataFloat && cardAddrLow)
        else $error("16-bit pins not parked");
    hw_suspend_a: assert property (!hw_suspend_n |=> !pciIfEnable && !txnAccept)
        else $error("host interface live in hardware suspend");
    keep_context_a: assert property (
        !host_bus_reset_n && (!hw_suspend_n || (inD3 && pmeEnable)) && !eventClear
        |=> (pmeEvents & $past(pmeEvents)) == $past(pmeEvents)) else $error("host reset cleared protected context");

endmodule : bridge_power_state_control

`default_nettype wire

// ==== bench/host_pm_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module host_pm_model #(
    parameter int LEAD = 20000
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic hostRstReq,
    input  wire logic suspReq,
    output var  logic hw_suspend_n,
    output var  logic host_bus_reset_n
);
    int cnt;

    // Supplies are taken as already on; the global reset may come first.
    // Suspend lifts one edge after the global reset, the host reset only after LEAD clocks.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt              <= 0;
            hw_suspend_n     <= 1'b0;
            host_bus_reset_n <= 1'b0;
        end else begin
            hw_suspend_n     <= !suspReq;
            if (cnt < LEAD) cnt <= cnt + 1;
            host_bus_reset_n <= (cnt >= LEAD) && !hostRstReq;
        end
    end
endmodule : host_pm_model

`default_nettype wire

// ==== bench/bridge_power_state_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module bridge_power_state_control_tb;
    import bridge_power_pkg::*;
    logic sys_clk, rstn, host_bus_reset_n, hw_suspend_n, hostRstReq, suspReq;
    logic stateWrite, pmeEnable, eventClear, auxPowerOnly, cardPresent, cardIsCardbus;
    logic cardReadyBusy, cardBattWarn, cardRingInd, pciClkStopped, pciClkSlow;
    logic cardClkRunAck, irqReq, txnValid, txnIsConfig;
    logic [1:0] stateReq;
    logic [3:0] eventMask, pmeEvents;
    logic [4:0] powerState;
    logic cardClkEnable, cardClkStopReq, cardBusReset_n, card16Reset, socketQuiet;
    logic cardDataFloat, cardAddrLow, cbParLow, cbGntHigh, pciIfEnable, intOut;
    logic txnAccept, txnReject, pmeOe_n;
    int n_mismatch, checks_done, cycles;

    host_pm_model #(.LEAD(32)) host (.sys_clk, .rstn, .hostRstReq, .suspReq, .hw_suspend_n, .host_bus_reset_n);

    bridge_power_state_control dut (.sys_clk, .rstn, .host_bus_reset_n, .hw_suspend_n, .stateWrite,
        .stateReq, .pmeEnable, .eventMask, .eventClear, .auxPowerOnly, .cardPresent, .cardIsCardbus,
        .cardReadyBusy, .cardBattWarn, .cardRingInd, .pciClkStopped, .pciClkSlow, .cardClkRunAck,
        .irqReq, .txnValid, .txnIsConfig, .powerState, .pmeEvents, .cardClkEnable, .cardClkStopReq,
        .cardBusReset_n, .card16Reset, .socketQuiet, .cardDataFloat, .cardAddrLow, .cbParLow,
        .cbGntHigh, .pciIfEnable, .intOut, .txnAccept, .txnReject, .pmeOe_n);

    // Free-running 200 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // A hang counts as a mismatch and goes straight to the verdict.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task stop_test();
        $display("counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Lets n edges land, then samples settled outputs.
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task req(input logic [1:0] code);
        @(posedge sys_clk);
        stateWrite <= 1'b1;
        stateReq   <= code;
        @(posedge sys_clk);
        stateWrite <= 1'b0;
        #1;
    endtask : req

    // The answer is a one-cycle pulse on the edge that takes the offer.
    task txn(input logic cfg, input logic acc);
        @(posedge sys_clk);
        txnValid    <= 1'b1;
        txnIsConfig <= cfg;
        @(posedge sys_clk);
        txnValid    <= 1'b0;
        #1;
        chk("txnAccept", acc, txnAccept);
        chk("txnReject", !acc, txnReject);
    endtask : txn

    task wait_pme();
        for (int i = 0; i < 8 && pmeOe_n !== 1'b0; i++) settle(1);
    endtask : wait_pme

    task boot();
        @(posedge sys_clk) rstn <= 1'b0;
        settle(16);
        chk("powerState", PS_D0, powerState);
        chk("pmeOe_n", 1, pmeOe_n);
        @(posedge sys_clk) rstn <= 1'b1;
        for (int i = 0; i < 200 && host_bus_reset_n !== 1'b1; i++) settle(1);
        settle(3);
        chk("pciIfEnable", 1, pciIfEnable);
        $display("test boot done");
    endtask : boot

    task t_d0d1();
        @(posedge sys_clk) irqReq <= 1'b1;
        settle(2);
        chk("intOut", 1, intOut);
        txn(1'b0, 1'b1);
        req(2'h1);
        chk("powerState", PS_D1, powerState);
        chk("cardClkEnable", 1, cardClkEnable);
        settle(1);
        chk("intOut", 0, intOut);
        txn(1'b0, 1'b0);
        txn(1'b1, 1'b1);
        $display("test d1 done");
    endtask : t_d0d1

    task t_d2();
        req(2'h2);
        chk("powerState", PS_D2, powerState);
        settle(1);
        chk("cardClkStopReq", 1, cardClkStopReq);
        chk("cardClkEnable", 1, cardClkEnable);
        @(posedge sys_clk) cardClkRunAck <= 1'b1;
        settle(3);
        chk("cardClkEnable", 0, cardClkEnable);
        chk("socketQuiet", 1, socketQuiet);
        chk("cbParLow", 1, cbParLow);
        chk("cbGntHigh", 1, cbGntHigh);
        chk("cardBusReset_n", 0, cardBusReset_n);
        $display("test d2 done");
    endtask : t_d2

    // Host reset arrives while a PME is armed; the event context must survive it.
    task t_d3();
        req(2'h3);
        chk("powerState", PS_D3HOT, powerState);
        chk("cardClkEnable", 0, cardClkEnable);
        chk("cardBusReset_n", 0, cardBusReset_n);
        @(posedge sys_clk);
        pmeEnable     <= 1'b1;
        cardReadyBusy <= 1'b1;
        wait_pme();
        chk("pmeOe_n", 0, pmeOe_n);
        chk("pmeEvents", 4'h2, pmeEvents);
        @(posedge sys_clk) hostRstReq <= 1'b1;
        settle(3);
        @(posedge sys_clk) hostRstReq <= 1'b0;
        settle(3);
        chk("powerState", PS_D3HOT, powerState);
        chk("pmeEvents", 4'h2, pmeEvents);
        @(posedge sys_clk);
        eventClear    <= 1'b1;
        pmeEnable     <= 1'b0;
        cardClkRunAck <= 1'b0;
        @(posedge sys_clk) eventClear <= 1'b0;
        req(2'h0);
        chk("powerState", PS_D0, powerState);
        chk("pciIfEnable", 0, pciIfEnable);
        req(2'h1);
        chk("powerState", PS_D0, powerState);
        settle(14);
        chk("pciIfEnable", 0, pciIfEnable);
        settle(3);
        chk("pciIfEnable", 0, pciIfEnable);
        settle(1);
        chk("pciIfEnable", 1, pciIfEnable);
        chk("cardBusReset_n", 1, cardBusReset_n);
        $display("test d3hot done");
    endtask : t_d3

    // A slowed host clock parks a 16-bit socket the same way as D2.
    task t_q16();
        @(posedge sys_clk);
        cardIsCardbus <= 1'b0;
        pciClkSlow    <= 1'b1;
        cardClkRunAck <= 1'b1;
        settle(4);
        chk("socketQuiet", 1, socketQuiet);
        chk("cardDataFloat", 1, cardDataFloat);
        chk("cardAddrLow", 1, cardAddrLow);
        @(posedge sys_clk) hostRstReq <= 1'b1;
        settle(3);
        chk("card16Reset", 1, card16Reset);
        @(posedge sys_clk) hostRstReq <= 1'b0;
        settle(3);
        chk("card16Reset", 0, card16Reset);
        chk("socketQuiet", 1, socketQuiet);
        @(posedge sys_clk);
        cardIsCardbus <= 1'b1;
        pciClkSlow    <= 1'b0;
        cardClkRunAck <= 1'b0;
        settle(4);
        chk("socketQuiet", 0, socketQuiet);
        $display("test park done");
    endtask : t_q16

    task t_hws();
        req(2'h1);
        @(posedge sys_clk) suspReq <= 1'b1;
        settle(3);
        chk("pciIfEnable", 0, pciIfEnable);
        txn(1'b1, 1'b0);
        @(posedge sys_clk) hostRstReq <= 1'b1;
        settle(3);
        @(posedge sys_clk) hostRstReq <= 1'b0;
        settle(3);
        chk("powerState", PS_D1, powerState);
        @(posedge sys_clk) suspReq <= 1'b0;
        settle(3);
        $display("test suspend done");
    endtask : t_hws

    task t_cold();
        req(2'h3);
        @(posedge sys_clk);
        auxPowerOnly <= 1'b1;
        pmeEnable    <= 1'b1;
        settle(3);
        chk("powerState", PS_D3COLD, powerState);
        // The pin must fall before any further clock edge arrives.
        @(posedge sys_clk) cardRingInd <= 1'b1;
        #1;
        chk("pmeOe_n", 0, pmeOe_n);
        $display("test d3cold done");
    endtask : t_cold

    // Main sequence; a second global reset separates the cold test from the rest.
    initial begin
        {stateWrite, pmeEnable, eventClear, auxPowerOnly, cardReadyBusy, cardBattWarn} = '0;
        {cardRingInd, pciClkStopped, pciClkSlow, cardClkRunAck, irqReq, txnValid} = '0;
        {txnIsConfig, hostRstReq, suspReq, rstn} = '0;
        stateReq      = 2'h0;
        eventMask     = 4'hF;
        cardPresent   = 1'b1;
        cardIsCardbus = 1'b1;
        n_mismatch    = 0;
        checks_done   = 0;
        boot();
        t_d0d1();
        t_d2();
        t_d3();
        t_q16();
        t_hws();
        boot();
        t_cold();
        stop_test();
    end
endmodule : bridge_power_state_control_tb

`default_nettype wire
